/* File: src/tdo_top.sv */
`timescale 1ns/100ps
module tdo_top #(
	parameter int MS_CYCLES        = tdo_pkg::MS_CYCLES,
	parameter int HEALTH_CYCLES    = tdo_pkg::HEALTH_CYCLES,
	parameter int TONE_HALF_CYCLES = tdo_pkg::TONE_HALF_CYCLES
) (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     nrst,
	// Straps
	input  wire logic                     mode_strap_a,
	input  wire logic                     mode_strap_b,
	input  wire logic [1:0]               gain_sense,
	// Acquisition front end
	output logic                          burst_req,
	input  wire logic                     sample_valid,
	input  wire logic [tdo_pkg::SIG_W-1:0] sample,
	// Detect output pin
	output logic                          detect_out,
	output logic                          detect_oe,
	// Sense pins as piezo bridge
	output logic                          sense_pin_a_o,
	output logic                          sense_pin_a_oe,
	output logic                          sense_pin_b_o,
	output logic                          sense_pin_b_oe,
	// Status
	output logic                          detect_active,
	output logic                          recal_pending,
	output logic [tdo_pkg::SIG_W-1:0]     reference_level,
	output tdo_pkg::tdo_mode_t            mode_sel,
	output tdo_pkg::tdo_gain_t            gain_sel
);
	import tdo_pkg::*;

	typedef enum logic [1:0] {
		ST_INIT,
		ST_WAIT,
		ST_HEALTH,
		ST_ACQ
	} tdo_state_t;

	tdo_state_t        state_q;
	logic              straps_taken_q;
	logic [DIV_W-1:0]  div_q;
	logic              ms_tick;
	logic [MS_W-1:0]   gap_cnt_q;
	logic [MS_W-1:0]   gap_len_q;
	logic [HEALTH_W-1:0] hcnt_q;
	logic              health_done;
	logic              eval;

	logic [SIG_W-1:0]  ref_q;
	logic [2:0]        integ_q;
	logic [3:0]        drift_q;
	logic              conf_q;
	logic              conf_prev_q;
	logic              recal_q;
	logic              rise;

	logic [SIG_W-1:0]  delta;
	logic [SIG_W:0]    thr;
	logic [SIG_W:0]    drop;
	logic              above;
	logic              released;

	logic [MS_W-1:0]   tmo_q;
	logic [MS_W-1:0]   tmo_lim;
	logic              expire;
	logic [MS_W-1:0]   pulse_cnt_q;
	logic              pulse_q;

	tdo_tone_if tif ();

	// ------------------------------------------------------------
	// Millisecond enable
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div_q <= '0;
		end else if (div_q == DIV_W'(MS_CYCLES - 1)) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	assign ms_tick = (div_q == DIV_W'(MS_CYCLES - 1));

	// ------------------------------------------------------------
	// Strap capture after reset release
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			straps_taken_q <= 1'b0;
			mode_sel       <= MODE_DC_SHORT;
			gain_sel       <= GAIN_HIGH;
		end else if (!straps_taken_q) begin
			straps_taken_q <= 1'b1;
			case ({mode_strap_a, mode_strap_b})
				2'h3:    mode_sel <= MODE_DC_SHORT;
				2'h2:    mode_sel <= MODE_DC_LONG;
				2'h0:    mode_sel <= MODE_TOGGLE;
				default: mode_sel <= MODE_PULSE;
			endcase
			case (gain_sense)
				GSENSE_TO_B: gain_sel <= GAIN_MED;
				GSENSE_TO_A: gain_sel <= GAIN_LOW;
				default:     gain_sel <= GAIN_HIGH;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Burst sequencer
	// ------------------------------------------------------------
	assign health_done = (state_q == ST_HEALTH) &&
	                     (hcnt_q == HEALTH_W'(HEALTH_CYCLES - 1));
	assign burst_req   = health_done;
	assign eval        = (state_q == ST_ACQ) && sample_valid;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q   <= ST_INIT;
			gap_cnt_q <= '0;
			hcnt_q    <= '0;
		end else begin
			case (state_q)
				ST_INIT: begin
					state_q <= ST_HEALTH;
				end
				ST_WAIT: begin
					if (ms_tick) begin
						if (gap_cnt_q >= gap_len_q - 1'b1) begin
							gap_cnt_q <= '0;
							state_q   <= ST_HEALTH;
						end else begin
							gap_cnt_q <= gap_cnt_q + 1'b1;
						end
					end
				end
				ST_HEALTH: begin
					if (health_done) begin
						hcnt_q  <= '0;
						state_q <= ST_ACQ;
					end else begin
						hcnt_q <= hcnt_q + 1'b1;
					end
				end
				ST_ACQ: begin
					if (sample_valid) begin
						gap_cnt_q <= '0;
						state_q   <= ST_WAIT;
					end
				end
				default: begin
					state_q <= ST_INIT;
				end
			endcase
		end
	end

	// Gap after each burst depends on the integrator
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gap_len_q <= MS_W'(BURST_GAP_MS);
		end else if (eval) begin
			if (!recal_q && !conf_q && above &&
			    (integ_q + 1'b1) < INTEG_LIMIT) begin
				gap_len_q <= MS_W'(CONFIRM_GAP_MS);
			end else begin
				gap_len_q <= MS_W'(BURST_GAP_MS);
			end
		end
	end

	// ------------------------------------------------------------
	// Threshold and hysteresis
	// ------------------------------------------------------------
	always_comb begin
		case (gain_sel)
			GAIN_MED: delta = THR_MED_GAIN;
			GAIN_LOW: delta = THR_LOW_GAIN;
			default:  delta = THR_HIGH_GAIN;
		endcase
	end

	assign thr      = {1'b0, ref_q} + {1'b0, delta};
	assign drop     = thr - {1'b0, tdo_hyst(delta)};
	assign above    = ({1'b0, sample} >= thr);
	assign released = ({1'b0, sample} < drop);

	// ------------------------------------------------------------
	// Reference, integrator and detection state
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ref_q   <= '0;
			integ_q <= '0;
			drift_q <= '0;
			conf_q  <= 1'b0;
			recal_q <= 1'b1;
		end else if (expire) begin
			conf_q  <= 1'b0;
			integ_q <= '0;
			recal_q <= 1'b1;
		end else if (eval) begin
			if (recal_q) begin
				ref_q   <= sample;
				integ_q <= '0;
				drift_q <= '0;
				conf_q  <= 1'b0;
				recal_q <= 1'b0;
			end else if (conf_q) begin
				if (released) begin
					conf_q <= 1'b0;
				end
				drift_q <= '0;
			end else if (above) begin
				if ((integ_q + 1'b1) == INTEG_LIMIT) begin
					conf_q  <= 1'b1;
					integ_q <= '0;
				end else begin
					integ_q <= integ_q + 1'b1;
				end
			end else begin
				integ_q <= '0;
				if (sample > ref_q) begin
					if (drift_q >= DRIFT_UP_BURSTS - 1'b1) begin
						ref_q   <= ref_q + DRIFT_STEP;
						drift_q <= '0;
					end else begin
						drift_q <= drift_q + 1'b1;
					end
				end else if (sample < ref_q) begin
					if (drift_q >= DRIFT_DN_BURSTS - 1'b1) begin
						ref_q   <= ref_q - DRIFT_STEP;
						drift_q <= '0;
					end else begin
						drift_q <= drift_q + 1'b1;
					end
				end else begin
					drift_q <= '0;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			conf_prev_q <= 1'b0;
		end else begin
			conf_prev_q <= conf_q;
		end
	end

	assign rise = conf_q && !conf_prev_q;

	// ------------------------------------------------------------
	// Detection timeout
	// ------------------------------------------------------------
	assign tmo_lim = (mode_sel == MODE_DC_LONG) ? MS_W'(TMO_LONG_MS) :
	                 MS_W'(TMO_SHORT_MS);
	assign expire  = conf_q && ms_tick && (tmo_q == tmo_lim - 1'b1);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tmo_q <= '0;
		end else if (!conf_q || expire) begin
			tmo_q <= '0;
		end else if (ms_tick) begin
			tmo_q <= tmo_q + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Output pulse timer
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pulse_q     <= 1'b0;
			pulse_cnt_q <= '0;
		end else if (rise && mode_sel == MODE_PULSE) begin
			pulse_q     <= 1'b1;
			pulse_cnt_q <= '0;
		end else if (pulse_q && ms_tick) begin
			if (pulse_cnt_q == MS_W'(PULSE_MS - 1)) begin
				pulse_q <= 1'b0;
			end
			pulse_cnt_q <= pulse_cnt_q + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Detect output
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			detect_out <= 1'b0;
		end else begin
			case (mode_sel)
				MODE_TOGGLE: begin
					if (rise) begin
						detect_out <= ~detect_out;
					end
				end
				MODE_PULSE: begin
					detect_out <= pulse_q;
				end
				default: begin
					detect_out <= conf_q && !expire;
				end
			endcase
		end
	end

	assign detect_oe = (state_q != ST_HEALTH);

	// ------------------------------------------------------------
	// Piezo tone
	// ------------------------------------------------------------
	assign tif.ms_tick = ms_tick;
	assign tif.start   = rise && (mode_sel != MODE_PULSE);

	tdo_tone #(
		.HALF_CYCLES (TONE_HALF_CYCLES)
	) u_tone (
		.clk  (clk),
		.nrst (nrst),
		.tif  (tif)
	);

	assign sense_pin_a_o  = tif.busy && tif.phase;
	assign sense_pin_b_o  = tif.busy && !tif.phase;
	assign sense_pin_a_oe = tif.busy;
	assign sense_pin_b_oe = tif.busy;

	// ------------------------------------------------------------
	// Status
	// ------------------------------------------------------------
	assign detect_active   = conf_q;
	assign recal_pending   = recal_q;
	assign reference_level = ref_q;

endmodule

/* File: src/tdo_pkg.sv */
package tdo_pkg;

	// ------------------------------------------------------------
	// Clock and time base
	// ------------------------------------------------------------
	localparam int CLK_HZ        = 250_000_000;
	localparam int MS_PER_S      = 1000;
	localparam int US_PER_S      = 1_000_000;
	localparam int MS_CYCLES     = CLK_HZ / MS_PER_S;
	localparam int DIV_W         = 18;

	// ------------------------------------------------------------
	// Sequencing times
	// ------------------------------------------------------------
	localparam int BURST_GAP_MS   = 95;
	localparam int CONFIRM_GAP_MS = 2;
	localparam int PULSE_MS       = 95;
	localparam int TONE_MS        = 95;
	localparam int TMO_SHORT_S    = 10;
	localparam int TMO_LONG_S     = 60;
	localparam int TMO_SHORT_MS   = TMO_SHORT_S * MS_PER_S;
	localparam int TMO_LONG_MS    = TMO_LONG_S * MS_PER_S;
	localparam int MS_W           = 16;

	localparam int HEALTH_US      = 350;
	localparam int HEALTH_CYCLES  = (HEALTH_US * (CLK_HZ / US_PER_S));
	localparam int HEALTH_W       = 17;

	localparam int TONE_HZ          = 4000;
	localparam int TONE_HALF_CYCLES = CLK_HZ / (2 * TONE_HZ);
	localparam int TONE_W           = 15;

	// ------------------------------------------------------------
	// Signal processing
	// ------------------------------------------------------------
	localparam int SIG_W = 16;
	localparam logic [SIG_W-1:0] THR_HIGH_GAIN = 16'h0010;
	localparam logic [SIG_W-1:0] THR_MED_GAIN  = 16'h0020;
	localparam logic [SIG_W-1:0] THR_LOW_GAIN  = 16'h0040;
	localparam int HYST_PCT = 17;
	localparam int PCT_FULL = 100;

	localparam logic [2:0] INTEG_LIMIT     = 3'h4;
	localparam logic [3:0] DRIFT_UP_BURSTS = 4'h8;
	localparam logic [3:0] DRIFT_DN_BURSTS = 4'h2;
	localparam logic [SIG_W-1:0] DRIFT_STEP = 16'h0001;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_DC_SHORT,
		MODE_DC_LONG,
		MODE_TOGGLE,
		MODE_PULSE
	} tdo_mode_t;

	typedef enum logic [1:0] {
		GAIN_HIGH,
		GAIN_MED,
		GAIN_LOW
	} tdo_gain_t;

	// Gain strap sense code: bit 0 tied to sense pin a, bit 1 to b
	localparam logic [1:0] GSENSE_TO_A = 2'h1;
	localparam logic [1:0] GSENSE_TO_B = 2'h2;

	function automatic logic [SIG_W-1:0] tdo_hyst(
		input logic [SIG_W-1:0] delta
	);
		int prod;
		prod = (int'(delta) * HYST_PCT) / PCT_FULL;
		return prod[SIG_W-1:0];
	endfunction

endpackage

/* File: src/tdo_tone_if.sv */
`timescale 1ns/100ps
interface tdo_tone_if;
	logic ms_tick;
	logic start;
	logic busy;
	logic phase;

	modport ctrl (output ms_tick, output start, input busy, input phase);
	modport tone (input ms_tick, input start, output busy, output phase);
endinterface

/* File: src/tdo_tone.sv */
`timescale 1ns/100ps
module tdo_tone #(
	parameter int HALF_CYCLES = tdo_pkg::TONE_HALF_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Control from the decision logic
	tdo_tone_if.tone tif
);
	import tdo_pkg::*;

	logic [MS_W-1:0]   dur_q;
	logic [TONE_W-1:0] half_q;

	// ------------------------------------------------------------
	// Tone duration
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tif.busy <= 1'b0;
			dur_q    <= '0;
		end else if (tif.start) begin
			tif.busy <= 1'b1;
			dur_q    <= '0;
		end else if (tif.busy && tif.ms_tick) begin
			if (dur_q == MS_W'(TONE_MS - 1)) begin
				tif.busy <= 1'b0;
			end
			dur_q <= dur_q + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Square wave for the bridge
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			half_q    <= '0;
			tif.phase <= 1'b0;
		end else if (!tif.busy || tif.start) begin
			half_q    <= '0;
			tif.phase <= 1'b0;
		end else if (half_q == TONE_W'(HALF_CYCLES - 1)) begin
			half_q    <= '0;
			tif.phase <= ~tif.phase;
		end else begin
			half_q <= half_q + 1'b1;
		end
	end

endmodule

/* File: verif/tdo_fe_model.sv */
`timescale 1ns/100ps
module tdo_fe_model (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      nrst,
	// Burst handshake
	input  wire logic                      burst_req,
	output logic                           sample_valid,
	output logic [tdo_pkg::SIG_W-1:0]      sample,
	// Raw level to report and answer delay, 0 stalls
	input  wire logic [tdo_pkg::SIG_W-1:0] level,
	input  wire logic [3:0]                lat
);
	import tdo_pkg::*;
	logic       pend_q;
	logic [3:0] cnt_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pend_q       <= 1'b0;
			cnt_q        <= 4'h0;
			sample_valid <= 1'b0;
			sample       <= '0;
		end else begin
			sample_valid <= 1'b0;
			// Junk on the result lines outside the valid cycle
			sample       <= ~sample;
			if (burst_req) begin
				pend_q <= 1'b1;
				cnt_q  <= 4'h1;
			end else if (pend_q && lat != 4'h0) begin
				cnt_q <= cnt_q + 4'h1;
				if (cnt_q >= lat) begin
					pend_q       <= 1'b0;
					sample_valid <= 1'b1;
					sample       <= level;
				end
			end
		end
	end
endmodule

/* File: verif/tdo_chk.sv */
`timescale 1ns/100ps
module tdo_chk #(
	parameter int HEALTH_CYCLES = 5
) (
	input wire logic                      clk,
	input wire logic                      nrst,
	input wire logic                      burst_req,
	input wire logic                      detect_out,
	input wire logic                      detect_oe,
	input wire logic                      sense_pin_a_o,
	input wire logic                      sense_pin_a_oe,
	input wire logic                      sense_pin_b_o,
	input wire logic                      sense_pin_b_oe,
	input wire logic                      detect_active,
	input wire logic                      recal_pending,
	input wire logic [tdo_pkg::SIG_W-1:0] reference_level,
	input wire tdo_pkg::tdo_mode_t        mode_sel,
	input wire tdo_pkg::tdo_gain_t        gain_sel
);
	import tdo_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	int   lo_q;
	logic up_q;

	// Length of the current released-output stretch
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lo_q <= 0;
			up_q <= 1'b0;
		end else begin
			lo_q <= detect_oe ? 0 : lo_q + 1;
			up_q <= 1'b1;
		end
	end

	a_health_window: assert property (
		burst_req |-> !detect_oe && lo_q == HEALTH_CYCLES - 1)
		else $error("health window length wrong");
	a_oe_back: assert property (
		burst_req |=> detect_oe) else $error("output not driven again");
	// A timeout drops the output in the same cycle as the detection
	a_dc_follow: assert property (
		(mode_sel == MODE_DC_SHORT || mode_sel == MODE_DC_LONG)
		|-> detect_out == ($past(detect_active) && !$rose(recal_pending)))
		else $error("dc output does not follow detection");
	a_no_pulse_tone: assert property (
		mode_sel == MODE_PULSE |-> !sense_pin_a_oe && !sense_pin_b_oe)
		else $error("tone in pulse mode");
	a_bridge_diff: assert property (
		sense_pin_a_oe |-> sense_pin_b_oe && sense_pin_a_o != sense_pin_b_o)
		else $error("tone not differential");
	a_tone_start: assert property (
		$rose(detect_active) && mode_sel != MODE_PULSE |=> sense_pin_a_oe)
		else $error("tone did not start");
	a_ref_frozen: assert property (
		detect_active && $past(detect_active) |-> $stable(reference_level))
		else $error("reference moved during detection");
	a_toggle_flip: assert property (
		mode_sel == MODE_TOGGLE && $rose(detect_active)
		|=> detect_out != $past(detect_out)) else $error("toggle missed");
	a_pulse_rise: assert property (
		mode_sel == MODE_PULSE && $rose(detect_active) |-> ##2 detect_out)
		else $error("pulse did not start");
	// Skip the capture edge itself, where the reset value is replaced
	a_straps_held: assert property (
		up_q && $past(up_q) |-> $stable(mode_sel) && $stable(gain_sel))
		else $error("strap selection changed");
endmodule

bind tdo_top tdo_chk #(.HEALTH_CYCLES(HEALTH_CYCLES)) u_chk (
	.clk(clk), .nrst(nrst), .burst_req(burst_req), .detect_out(detect_out),
	.detect_oe(detect_oe), .sense_pin_a_o(sense_pin_a_o),
	.sense_pin_a_oe(sense_pin_a_oe), .sense_pin_b_o(sense_pin_b_o),
	.sense_pin_b_oe(sense_pin_b_oe), .detect_active(detect_active),
	.recal_pending(recal_pending),
	.reference_level(reference_level), .mode_sel(mode_sel),
	.gain_sel(gain_sel));

/* File: verif/tb_touch_detect_output_logic.sv */
`timescale 1ns/100ps
module tb_touch_detect_output_logic;
	import tdo_pkg::*;
	localparam int MSC = 2;
	logic clk = 0, nrst = 0, sa = 1, sb = 1, sv, bq, dout, doe, act, rp;
	logic ao, aoe, bo, boe;
	logic [1:0] gs = 2'h0;
	logic [3:0] lat = 4'h3;
	logic [15:0] lvl = 16'h0100, smp, rl;
	tdo_mode_t ms;
	tdo_gain_t gn;
	int n_errors = 0, n_checks = 0, cyc = 0, g, n;

	tdo_top #(.MS_CYCLES(MSC), .HEALTH_CYCLES(5), .TONE_HALF_CYCLES(2)) uut (
		.clk(clk), .nrst(nrst), .mode_strap_a(sa), .mode_strap_b(sb),
		.gain_sense(gs), .burst_req(bq), .sample_valid(sv), .sample(smp),
		.detect_out(dout), .detect_oe(doe), .sense_pin_a_o(ao),
		.sense_pin_a_oe(aoe), .sense_pin_b_o(bo), .sense_pin_b_oe(boe),
		.detect_active(act), .recal_pending(rp), .reference_level(rl),
		.mode_sel(ms), .gain_sel(gn));
	tdo_fe_model fe (.clk(clk), .nrst(nrst), .burst_req(bq),
		.sample_valid(sv), .sample(smp), .level(lvl), .lat(lat));

	initial forever #2 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			finish_test();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wt(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic burst(input logic [15:0] v);
		lvl = v;
		g = 0;
		do begin
			@(posedge clk);
			g++;
		end while (sv !== 1'b1);
		#1;
	endtask

	task automatic pwr(input logic a, input logic b, input logic [1:0] c,
			input tdo_mode_t em, input tdo_gain_t eg);
		@(posedge clk);
		#1;
		nrst = 0;
		sa = a;
		sb = b;
		gs = c;
		lat = 4'h3;
		wt(4);
		nrst = 1;
		wt(3);
		chk(16'(ms), 16'(em));
		chk(16'(gn), 16'(eg));
		sa = ~a;
		sb = ~b;
		gs = ~c;
		wt(2);
		chk(16'(ms), 16'(em));
		burst(16'h0100);
		wt(1);
		chk(rl, 16'h0100);
	endtask

	task automatic t_dc;
		pwr(1, 1, 2'h0, MODE_DC_SHORT, GAIN_HIGH);
		burst(16'h0110);
		burst(16'h0110);
		chk(16'(g < 30), 16'h1);
		burst(16'h0110);
		burst(16'h010f);
		wt(3);
		chk(16'(act), 16'h0);
		burst(16'h0110);
		chk(16'(g >= 95 * MSC), 16'h1);
		repeat (3) burst(16'h0110);
		wt(3);
		chk({act, dout, aoe}, 16'h7);
		burst(16'h010e);
		wt(3);
		chk(16'(act), 16'h1);
		burst(16'h010d);
		wt(3);
		chk({act, dout}, 16'h0);
		chk(rl, 16'h0100);
		repeat (2) burst(16'h00f0);
		wt(1);
		chk(rl, 16'h00ff);
		repeat (7) burst(16'h0105);
		wt(1);
		chk(rl, 16'h00ff);
		repeat (4) burst(16'h0120);
		lat = 4'h0;
		n = 0;
		while (act === 1'b1 && n < 21000) begin
			wt(1);
			n++;
		end
		chk(16'(n >= 20000 - 10 && n <= 20000 + 10), 16'h1);
		wt(1);
		chk({dout, rp}, 16'h1);
		lat = 4'h1;
		burst(16'h0130);
		wt(1);
		chk(rl, 16'h0130);
		$display("test dc done");
	endtask

	task automatic t_tog;
		pwr(0, 0, GSENSE_TO_B, MODE_TOGGLE, GAIN_MED);
		burst(16'h011f);
		repeat (4) burst(16'h0120);
		wt(3);
		chk({act, dout, aoe}, 16'h7);
		burst(16'h0120);
		burst(16'h0100);
		wt(3);
		chk({act, dout}, 16'h1);
		repeat (4) burst(16'h0120);
		wt(3);
		chk({act, dout}, 16'h2);
		$display("test toggle done");
	endtask

	task automatic t_pls;
		pwr(0, 1, GSENSE_TO_A, MODE_PULSE, GAIN_LOW);
		repeat (4) burst(16'h0140);
		n = 0;
		repeat (400) begin
			@(posedge clk);
			if (dout === 1'b1)
				n++;
		end
		#1;
		chk(16'(n >= 95 * MSC - MSC && n <= 95 * MSC + MSC), 16'h1);
		chk({act, aoe, boe}, 16'h4);
		pwr(1, 0, 2'h3, MODE_DC_LONG, GAIN_HIGH);
		$display("test pulse done");
	endtask

	task automatic finish_test;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		wt(4);
		nrst = 1;
		t_dc();
		t_tog();
		t_pls();
		finish_test();
	end
endmodule
